//--- verilog/nidsc_defines.vh
`ifndef NIDSC_DEFINES_VH
`define NIDSC_DEFINES_VH

// ****************************************
// flash commands
// ****************************************
`define NIDSC_CMD_READ_SETUP 8'h00
`define NIDSC_CMD_READ_GO 8'h30
`define NIDSC_CMD_READ_ID 8'h90
`define NIDSC_CMD_STATUS 8'h70
`define NIDSC_CMD_EXT_STATUS 8'h7B
`define NIDSC_CMD_PROG_SETUP 8'h80
`define NIDSC_CMD_COPY_SETUP 8'h85
`define NIDSC_CMD_PROG_GO 8'h10
`define NIDSC_CMD_RESET 8'hFF

// ****************************************
// page geometry
// ****************************************
`define NIDSC_MAIN_BYTES 12'h0800
`define NIDSC_PAGE_BYTES 12'h0840
`define NIDSC_ADDR_CYCLES 3'h5

// ****************************************
// id byte layout
// ****************************************
`define NIDSC_ID4_PAGE_LSB 0
`define NIDSC_ID4_SPARE_BIT 2
`define NIDSC_ID4_ACC_LO_BIT 3
`define NIDSC_ID4_BLOCK_LSB 4
`define NIDSC_ID4_ORG_BIT 6
`define NIDSC_ID4_ACC_HI_BIT 7
`define NIDSC_ID5_PLANES_LSB 2
`define NIDSC_ID5_PSIZE_LSB 4
`define NIDSC_ID5_KEEP_MASK 8'h7C

// ****************************************
// status byte layout
// ****************************************
`define NIDSC_ST_FAIL_BIT 0
`define NIDSC_ST_SECERR_BIT 1
`define NIDSC_ST_VALID_BIT 2
`define NIDSC_ST_RDY_A_BIT 5
`define NIDSC_ST_RDY_B_BIT 6
`define NIDSC_ST_WP_BIT 7

// ****************************************
// register offsets
// ****************************************
`define NIDSC_OFF_ID_LOW 12'h000
`define NIDSC_OFF_GEOM 12'h004
`define NIDSC_OFF_EXT_STATUS 12'h008
`define NIDSC_OFF_SECT_ERR 12'h00C
`define NIDSC_OFF_IRQ_STATUS 12'h010
`define NIDSC_OFF_IRQ_MASK 12'h014
`define NIDSC_OFF_STATE 12'h018

// ****************************************
// reset values (id codes are arbitrary)
// ****************************************
`define NIDSC_RST_ID_LOW 24'h10_3C5A
`define NIDSC_RST_GEOM 16'h5495
`define NIDSC_RST_SECT_ERR 4'h0
`define NIDSC_RST_IRQ_MASK 3'h0

// ****************************************
// timing
// ****************************************
`define NIDSC_CLK_NS 50
`define NIDSC_TREAD_NS 25000
`define NIDSC_TPROG_NS 200000

`endif

//--- verilog/nidsc_sector_map.v
`timescale 1ns/1ns
`include "nidsc_defines.vh"

module nidsc_sector_map (
  // column in
  input wire [11:0] col,
  // decode out
  output wire [1:0] sector,
  output wire spare,
  output wire in_page
);

  wire [11:0] spare_off;

  assign spare = (col >= `NIDSC_MAIN_BYTES);
  assign in_page = (col < `NIDSC_PAGE_BYTES);
  assign spare_off = col - `NIDSC_MAIN_BYTES;
  // main: 512-byte ranges, spare: 16-byte ranges, same order
  assign sector = spare ? spare_off[5:4] : col[10:9];

endmodule

//--- verilog/nidsc_top.v
`timescale 1ns/1ns
`include "nidsc_defines.vh"

module nidsc_top (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // interrupt
  output reg irq,
  // flash pins
  input wire ce_n,
  input wire cle,
  input wire ale,
  input wire we_n,
  input wire re_n,
  input wire wp_n,
  input wire [7:0] io_in,
  output reg [7:0] io_out,
  output reg io_oe,
  output reg rb_n
);

  // ****************************************
  // constants
  // ****************************************
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_DIN = 3'd2;
  localparam [2:0] ST_BUSY = 3'd3;
  localparam [1:0] OUT_ID = 2'd0;
  localparam [1:0] OUT_STAT = 2'd1;
  localparam [1:0] OUT_EXT = 2'd2;
  localparam [1:0] OUT_DATA = 2'd3;
  localparam integer TREAD_I = `NIDSC_TREAD_NS / `NIDSC_CLK_NS;
  localparam integer TPROG_I = `NIDSC_TPROG_NS / `NIDSC_CLK_NS;
  // both counts fit twelve bits; the slice makes the cut explicit
  localparam [11:0] TREAD_CYC = TREAD_I[11:0];
  localparam [11:0] TPROG_CYC = TPROG_I[11:0];

  // ****************************************
  // state
  // ****************************************
  reg [2:0] state_r;
  reg [1:0] out_sel_r;
  reg [7:0] pend_r;
  reg [2:0] addr_cnt_r;
  reg [11:0] col_r;
  reg [2:0] id_idx_r;
  reg [11:0] busy_cnt_r;
  reg we_q_r;
  reg re_q_r;
  reg fail_r;
  reg secerr_r;
  reg valid_r;
  reg [23:0] id_low_r;
  reg [15:0] geom_r;
  reg [3:0] sect_err_r;
  reg [3:0] touched_r;
  reg [2:0] irq_stat_r;
  reg [2:0] irq_mask_r;
  reg [7:0] page_buf [0:2111];
  reg [7:0] byte_nxt;
  reg [7:0] ext_nxt;
  reg [7:0] stat_nxt;
  reg [31:0] rdata_nxt;
  reg rmap_nxt;
  reg ev_done;
  reg ev_secerr;
  reg ev_id;

  wire [1:0] cur_sector;
  wire cur_spare;
  wire cur_in_page;
  // pins are sampled; edges found against last sample
  wire we_rise = we_n & ~we_q_r & ~ce_n;
  wire re_rise = re_n & ~re_q_r & ~ce_n;
  wire cmd_wr = we_rise & cle & ~ale;
  wire addr_wr = we_rise & ale & ~cle;
  wire data_wr = we_rise & ~ale & ~cle;
  wire ready = (state_r != ST_BUSY);
  wire apb_acc = psel & penable & pready;
  wire apb_wr = apb_acc & pwrite;
  wire [7:0] buf_rd = page_buf[col_r];

  nidsc_sector_map u_map (
    .col(col_r),
    .sector(cur_sector),
    .spare(cur_spare),
    .in_page(cur_in_page)
  );

  // ****************************************
  // status and id bytes
  // ****************************************
  always @* begin
    stat_nxt = 8'h00;
    stat_nxt[`NIDSC_ST_FAIL_BIT] = fail_r;
    stat_nxt[`NIDSC_ST_RDY_A_BIT] = ready;
    stat_nxt[`NIDSC_ST_RDY_B_BIT] = ready;
    stat_nxt[`NIDSC_ST_WP_BIT] = wp_n;
    ext_nxt = 8'h00;
    ext_nxt[`NIDSC_ST_FAIL_BIT] = fail_r;
    ext_nxt[`NIDSC_ST_SECERR_BIT] = secerr_r;
    ext_nxt[`NIDSC_ST_VALID_BIT] = valid_r;
    ext_nxt[`NIDSC_ST_RDY_A_BIT] = ready;
    ext_nxt[`NIDSC_ST_RDY_B_BIT] = ready;
    ext_nxt[`NIDSC_ST_WP_BIT] = wp_n;
  end

  always @* begin
    byte_nxt = 8'h00;
    case (out_sel_r)
      OUT_ID: begin
        // geometry bytes carry fields
        case (id_idx_r)
          3'd0: byte_nxt = id_low_r[7:0];
          3'd1: byte_nxt = id_low_r[15:8];
          3'd2: byte_nxt = id_low_r[23:16];
          3'd3: byte_nxt = geom_r[7:0];
          3'd4: byte_nxt = geom_r[15:8];
          default: byte_nxt = 8'h00;
        endcase
      end
      OUT_STAT: byte_nxt = stat_nxt;
      OUT_EXT: byte_nxt = ext_nxt;
      OUT_DATA: byte_nxt = cur_in_page ? buf_rd : 8'hFF;
      default: byte_nxt = 8'h00;
    endcase
  end

  // ****************************************
  // flash command engine
  // ****************************************
  // ce_n gates edges and io_oe; no state is cleared when it rises
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      out_sel_r <= OUT_STAT;
      pend_r <= 8'h00;
      addr_cnt_r <= 3'h0;
      col_r <= 12'h000;
      id_idx_r <= 3'h0;
      busy_cnt_r <= 12'h000;
      we_q_r <= 1'b1;
      re_q_r <= 1'b1;
      fail_r <= 1'b0;
      secerr_r <= 1'b0;
      valid_r <= 1'b0;
      touched_r <= 4'h0;
      io_out <= 8'h00;
      io_oe <= 1'b0;
      rb_n <= 1'b1;
      ev_done <= 1'b0;
      ev_secerr <= 1'b0;
      ev_id <= 1'b0;
    end else begin
      we_q_r <= we_n;
      re_q_r <= re_n;
      io_out <= byte_nxt;
      io_oe <= ~ce_n & ~re_n;
      rb_n <= ready;
      ev_done <= 1'b0;
      ev_secerr <= 1'b0;
      ev_id <= 1'b0;
      if (cmd_wr && io_in == `NIDSC_CMD_RESET) begin
        state_r <= ST_IDLE;
        out_sel_r <= OUT_STAT;
        busy_cnt_r <= 12'h000;
      end else if (cmd_wr && io_in == `NIDSC_CMD_STATUS) begin
        out_sel_r <= OUT_STAT;
      end else if (cmd_wr && io_in == `NIDSC_CMD_EXT_STATUS) begin
        out_sel_r <= OUT_EXT;
      end else begin
        case (state_r)
          ST_IDLE, ST_ADDR, ST_DIN: begin
            if (cmd_wr) begin
              case (io_in)
                `NIDSC_CMD_READ_ID, `NIDSC_CMD_READ_SETUP,
                `NIDSC_CMD_PROG_SETUP, `NIDSC_CMD_COPY_SETUP: begin
                  pend_r <= io_in;
                  addr_cnt_r <= 3'h0;
                  touched_r <= 4'h0;
                  state_r <= ST_ADDR;
                end
                `NIDSC_CMD_READ_GO: begin
                  if (state_r == ST_ADDR && pend_r == `NIDSC_CMD_READ_SETUP &&
                      addr_cnt_r == `NIDSC_ADDR_CYCLES) begin
                    // each page needs its own command pair
                    busy_cnt_r <= TREAD_CYC;
                    state_r <= ST_BUSY;
                  end
                end
                `NIDSC_CMD_PROG_GO: begin
                  if (state_r == ST_DIN) begin
                    busy_cnt_r <= TPROG_CYC;
                    state_r <= ST_BUSY;
                  end
                end
                default: begin
                end
              endcase
            end else if (addr_wr && state_r == ST_ADDR) begin
              if (pend_r == `NIDSC_CMD_READ_ID) begin
                out_sel_r <= OUT_ID;
                id_idx_r <= 3'h0;
                state_r <= ST_IDLE;
                ev_id <= 1'b1;
              end else if (addr_cnt_r != `NIDSC_ADDR_CYCLES) begin
                addr_cnt_r <= addr_cnt_r + 3'h1;
                if (addr_cnt_r == 3'h0)
                  col_r <= {col_r[11:8], io_in};
                else if (addr_cnt_r == 3'h1)
                  col_r <= {io_in[3:0], col_r[7:0]};
                if (addr_cnt_r == 3'h4 && pend_r != `NIDSC_CMD_READ_SETUP)
                  state_r <= ST_DIN;
              end
            end else if (data_wr && state_r == ST_DIN) begin
              if (cur_in_page) begin
                col_r <= col_r + 12'h001;
                touched_r[cur_sector] <= 1'b1;
              end
            end
          end
          ST_BUSY: begin
            if (busy_cnt_r > 12'h001) begin
              busy_cnt_r <= busy_cnt_r - 12'h001;
            end else begin
              busy_cnt_r <= 12'h000;
              state_r <= ST_IDLE;
              ev_done <= 1'b1;
              if (pend_r == `NIDSC_CMD_READ_SETUP) begin
                out_sel_r <= OUT_DATA;
              end else begin
                fail_r <= ~wp_n;
                // check result is only meaningful after copy-back
                valid_r <= (pend_r == `NIDSC_CMD_COPY_SETUP);
                secerr_r <= (pend_r == `NIDSC_CMD_COPY_SETUP) & (|sect_err_r);
                ev_secerr <= (pend_r == `NIDSC_CMD_COPY_SETUP) & (|sect_err_r);
              end
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
      if (re_rise && state_r != ST_BUSY) begin
        if (out_sel_r == OUT_ID && id_idx_r != 3'h5)
          id_idx_r <= id_idx_r + 3'h1;
        // pointer parks past the last spare column
        if (out_sel_r == OUT_DATA && cur_in_page)
          col_r <= col_r + 12'h001;
      end
    end
  end

  // cells are modelled by the page register itself
  always @(posedge pclk) begin
    if (data_wr && state_r == ST_DIN && cur_in_page)
      page_buf[col_r] <= io_in;
  end

  // ****************************************
  // apb registers
  // ****************************************
  always @* begin
    rdata_nxt = 32'h0000_0000;
    rmap_nxt = 1'b1;
    case (paddr)
      `NIDSC_OFF_ID_LOW: rdata_nxt = {8'h00, id_low_r};
      `NIDSC_OFF_GEOM: rdata_nxt = {16'h0000, geom_r};
      `NIDSC_OFF_EXT_STATUS: rdata_nxt = {24'h00_0000, ext_nxt};
      `NIDSC_OFF_SECT_ERR: rdata_nxt = {28'h000_0000, sect_err_r};
      `NIDSC_OFF_IRQ_STATUS: rdata_nxt = {29'h0000_0000, irq_stat_r};
      `NIDSC_OFF_IRQ_MASK: rdata_nxt = {29'h0000_0000, irq_mask_r};
      `NIDSC_OFF_STATE:
        rdata_nxt = {4'h0, touched_r, 5'h00, state_r, cur_spare, cur_sector, 1'b0, col_r};
      default: rmap_nxt = 1'b0;
    endcase
  end

  // zero wait state: pready rises in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      id_low_r <= `NIDSC_RST_ID_LOW;
      geom_r <= `NIDSC_RST_GEOM;
      sect_err_r <= `NIDSC_RST_SECT_ERR;
      irq_mask_r <= `NIDSC_RST_IRQ_MASK;
      irq_stat_r <= 3'h0;
      irq <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~rmap_nxt;
      if (psel && !penable)
        prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
      if (apb_wr) begin
        case (paddr)
          `NIDSC_OFF_ID_LOW: id_low_r <= pwdata[23:0];
          `NIDSC_OFF_GEOM:
            // reserved plane-byte bits forced to zero
            geom_r <= {pwdata[15:8] & `NIDSC_ID5_KEEP_MASK, pwdata[7:0]};
          `NIDSC_OFF_SECT_ERR: sect_err_r <= pwdata[3:0];
          `NIDSC_OFF_IRQ_MASK: irq_mask_r <= pwdata[2:0];
          default: begin
          end
        endcase
      end
      // new events win over a same-cycle write-one clear
      if (apb_wr && paddr == `NIDSC_OFF_IRQ_STATUS)
        irq_stat_r <= (irq_stat_r & ~pwdata[2:0]) | {ev_id, ev_secerr, ev_done};
      else
        irq_stat_r <= irq_stat_r | {ev_id, ev_secerr, ev_done};
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

endmodule

//--- bench/nidsc_props.sv
`timescale 1ns/1ns
`include "nidsc_defines.vh"
module nidsc_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire ce_n,
  input wire cle,
  input wire we_n,
  input wire re_n,
  input wire wp_n,
  input wire [7:0] io_in,
  input wire [7:0] io_out,
  input wire io_oe,
  input wire rb_n
);
  reg we_q, re_q, ext_q, id_q;
  reg [2:0] cnt;
  wire cmd_t = !we_q && we_n && !ce_n && cle;
  wire ext_v = ext_q && io_oe;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // follows the pin decode so byte checks know what is on the bus
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      we_q <= 1'b1;
      re_q <= 1'b1;
      ext_q <= 1'b0;
      id_q <= 1'b0;
      cnt <= 3'h0;
    end else begin
      we_q <= we_n;
      re_q <= re_n;
      if (cmd_t) begin
        ext_q <= (io_in == `NIDSC_CMD_EXT_STATUS);
        id_q <= (io_in == `NIDSC_CMD_READ_ID);
        cnt <= 3'h0;
      end else if (!re_q && re_n && !ce_n && cnt != 3'h7) begin
        cnt <= cnt + 3'h1;
      end
    end
  end
  ext_spare_a: assert property (ext_v |-> io_out[4:3] == 2'b00)
    else $error("ext status spare bits set");
  ready_pair_a: assert property (ext_v |-> io_out[5] == io_out[6])
    else $error("ready bits differ");
  ext_ready_a: assert property (ext_v && rb_n && $past(rb_n) |-> io_out[6])
    else $error("ready bit low while ready");
  ext_wp_a: assert property (ext_v && wp_n == $past(wp_n, 2) |-> io_out[7] == wp_n)
    else $error("protect bit wrong");
  ce_oe_a: assert property ($past(ce_n) |-> !io_oe)
    else $error("bus driven while deselected");
  busy_min_a: assert property ($fell(rb_n) |-> !rb_n [*8])
    else $error("busy too short");
  id_five_a: assert property (id_q && io_oe && cnt == 3'h4 |-> (io_out & 8'h83) == 8'h00)
    else $error("id byte five reserved bits set");
  apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer timing");
endmodule
bind nidsc_top nidsc_props u_props (.pclk, .presetn, .psel, .penable, .pready, .ce_n, .cle,
  .we_n, .re_n, .wp_n, .io_in, .io_out, .io_oe, .rb_n);

//--- bench/nidsc_ctrl.sv
`timescale 1ns/1ns
module nidsc_ctrl (
  input wire pclk,
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic [7:0] io_in,
  input wire [7:0] io_out
);
  initial begin
    ce_n = 1'b1;
    cle = 1'b0;
    ale = 1'b0;
    we_n = 1'b1;
    re_n = 1'b1;
    io_in = 8'h00;
  end
  // every level held two samples since the device samples pins on pclk
  task automatic wr(input logic c, input logic a, input logic [7:0] d, input logic rel);
    ce_n <= 1'b0;
    cle <= c;
    ale <= a;
    io_in <= d;
    we_n <= 1'b0;
    repeat (2) @(posedge pclk);
    we_n <= 1'b1;
    repeat (2) @(posedge pclk);
    cle <= 1'b0;
    ale <= 1'b0;
    io_in <= ~d;
    ce_n <= rel;
    repeat (2) @(posedge pclk);
  endtask
  task automatic rd(output logic [7:0] d, input logic rel);
    ce_n <= 1'b0;
    re_n <= 1'b0;
    repeat (3) @(posedge pclk);
    d = io_out;
    re_n <= 1'b1;
    repeat (2) @(posedge pclk);
    ce_n <= rel;
    repeat (2) @(posedge pclk);
  endtask
endmodule

//--- bench/nidsc_top_tb.sv
`timescale 1ns/1ns
`include "nidsc_defines.vh"
module nidsc_top_tb;
  logic pclk, presetn, psel, penable, pwrite, wp_n, pready, pslverr, irq;
  logic ce_n, cle, ale, we_n, re_n, io_oe, rb_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [7:0] io_in, io_out, b, g;
  int n_errors, total_checks, k;
  int cols[10] = '{0, 511, 512, 1536, 2047, 2048, 2063, 2064, 2111, 2110};
  nidsc_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .ce_n, .cle, .ale, .we_n, .re_n, .wp_n, .io_in, .io_out,
    .io_oe, .rb_n);
  nidsc_ctrl u_c (.pclk, .ce_n, .cle, .ale, .we_n, .re_n, .io_in, .io_out);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      chk(0, 1);
      end_of_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp, input logic ee);
    logic e;
    apb(1'b0, a, 32'h0000_0000, rv, e);
    chk(rv, exp);
    chk(e, ee);
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, rv, e);
  endtask
  // stuck busy ends the run rather than hanging it
  task automatic wait_ready;
    int i;
    i = 0;
    chk(rb_n, 0);
    while (rb_n !== 1'b1 && i < 6000) begin
      @(posedge pclk);
      i++;
    end
    if (rb_n !== 1'b1) begin
      chk(0, 1);
      end_of_test();
    end
  endtask
  task automatic addr5(input logic [11:0] c);
    u_c.wr(1'b0, 1'b1, c[7:0], 1'b0);
    u_c.wr(1'b0, 1'b1, {4'h0, c[11:8]}, 1'b0);
    repeat (3) u_c.wr(1'b0, 1'b1, 8'h00, 1'b0);
  endtask
  task automatic id_chk(input logic [7:0] b4, input logic [7:0] b5);
    logic [39:0] e;
    e = {b5, b4, `NIDSC_RST_ID_LOW};
    u_c.wr(1'b1, 1'b0, 8'h90, 1'b0);
    u_c.wr(1'b0, 1'b1, 8'h00, 1'b0);
    for (int i = 0; i < 5; i++) begin
      u_c.rd(b, 1'b1);
      chk(b, e[8*i +: 8]);
    end
  endtask
  task automatic st_chk(input logic [7:0] x);
    u_c.wr(1'b1, 1'b0, 8'h7B, 1'b0);
    u_c.rd(b, 1'b0);
    chk(b, x);
  endtask
  function automatic logic [31:0] state_of(input int c);
    logic sp;
    sp = (c >= 2048);
    return {13'h0, 3'h2, sp, sp ? 2'((c - 2048) / 16) : 2'(c / 512), 1'b0, 12'(c)};
  endfunction
  initial begin
    n_errors = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    wp_n = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_reg(`NIDSC_OFF_ID_LOW, 32'h0010_3C5A, 1'b0);
    rd_reg(`NIDSC_OFF_GEOM, 32'h0000_5495, 1'b0);
    rd_reg(`NIDSC_OFF_IRQ_MASK, 32'h0000_0000, 1'b0);
    rd_reg(12'h01C, 32'h0000_0000, 1'b1);
    id_chk(8'h95, 8'h54);
    for (k = 1; k < 4; k++) begin
      g = 8'(8'h55 * k);
      wr_reg(`NIDSC_OFF_GEOM, {16'h0000, g, g});
      rd_reg(`NIDSC_OFF_GEOM, {16'h0000, g & 8'h7C, g}, 1'b0);
      id_chk(g, g & 8'h7C);
    end
    st_chk(8'hE0);
    wr_reg(`NIDSC_OFF_SECT_ERR, 32'h0000_0001);
    for (k = 0; k < 10; k++) begin
      u_c.wr(1'b1, 1'b0, 8'h85, 1'b0);
      addr5(12'(cols[k]));
      rd_reg(`NIDSC_OFF_STATE, state_of(cols[k]), 1'b0);
    end
    u_c.wr(1'b0, 1'b0, 8'hAA, 1'b1);
    u_c.wr(1'b0, 1'b0, 8'hBB, 1'b1);
    u_c.wr(1'b1, 1'b0, 8'h10, 1'b0);
    wait_ready();
    st_chk(8'hE6);
    rd_reg(`NIDSC_OFF_IRQ_STATUS, 32'h0000_0007, 1'b0);
    chk(irq, 0);
    wr_reg(`NIDSC_OFF_IRQ_MASK, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    chk(irq, 1);
    wr_reg(`NIDSC_OFF_IRQ_STATUS, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    u_c.wr(1'b1, 1'b0, 8'h00, 1'b0);
    addr5(12'h83E);
    u_c.wr(1'b1, 1'b0, 8'h30, 1'b0);
    wait_ready();
    rv = 32'hFFFF_BBAA;
    for (k = 0; k < 4; k++) begin
      u_c.rd(b, 1'b1);
      chk(b, rv[8*k +: 8]);
    end
    wr_reg(`NIDSC_OFF_SECT_ERR, 32'h0000_0000);
    wp_n <= 1'b0;
    u_c.wr(1'b1, 1'b0, 8'h80, 1'b0);
    addr5(12'h000);
    u_c.wr(1'b0, 1'b0, 8'h11, 1'b1);
    u_c.wr(1'b1, 1'b0, 8'h10, 1'b0);
    u_c.wr(1'b1, 1'b0, 8'h70, 1'b0);
    u_c.rd(b, 1'b0);
    chk(b, 8'h00);
    wait_ready();
    st_chk(8'h61);
    wr_reg(`NIDSC_OFF_EXT_STATUS, 32'h0000_00FF);
    rd_reg(`NIDSC_OFF_EXT_STATUS, 32'h0000_0061, 1'b0);
    u_c.wr(1'b1, 1'b0, 8'h00, 1'b0);
    addr5(12'h000);
    u_c.wr(1'b1, 1'b0, 8'h30, 1'b0);
    repeat (10) @(posedge pclk);
    u_c.wr(1'b1, 1'b0, 8'hFF, 1'b0);
    chk(rb_n, 1);
    u_c.rd(b, 1'b0);
    chk(b, 8'h61);
    end_of_test();
  end
endmodule
